// file: core/pifr_pkg.sv
// Package with offsets, field positions and reset values of the peripheral flag block.
package pifr_pkg;
  localparam int unsigned ADDR_W         = 4;
  localparam logic [3:0]  OFF_FLAGS_A    = 4'h0;
  localparam logic [3:0]  OFF_FLAGS_B    = 4'h1;
  localparam logic [3:0]  OFF_ENABLE_A   = 4'h2;
  localparam logic [3:0]  OFF_ENABLE_B   = 4'h3;
  localparam logic [3:0]  OFF_IRQ_CTRL   = 4'h4;
  localparam logic [3:0]  OFF_IRQ_STATUS = 4'h5;
  localparam logic [3:0]  OFF_IRQ_MASK   = 4'h6;
  localparam int unsigned BIT_T1_GATE    = 7;
  localparam int unsigned BIT_ADC_DONE   = 6;
  localparam int unsigned BIT_T2_MATCH   = 1;
  localparam int unsigned BIT_T1_OVF     = 0;
  localparam int unsigned BIT_NUM_OSC    = 2;
  localparam int unsigned BIT_GLOBAL_EN  = 7;
  localparam int unsigned BIT_PERIPH_EN  = 6;
  localparam logic [7:0]  IMPL_MASK_A    = 8'hc3;
  localparam logic [7:0]  IMPL_MASK_B    = 8'h04;
  localparam logic [7:0]  IMPL_MASK_CTRL = 8'hc0;
  localparam logic [7:0]  IMPL_MASK_STAT = 8'h01;
  localparam logic [7:0]  RST_REG        = 8'h00;
  localparam logic [7:0]  RST_RDATA      = 8'h00;
endpackage

// file: core/pifr_bus_if.sv
// Interface that carries the register bus between the top and the flag bank.
interface pifr_bus_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  modport master (output addr, output wdata, output wr);
  modport slave  (input addr, input wdata, input wr);
endinterface

// file: core/pifr_flag_bank.sv
// One 8-bit flag register with hardware set and software write.
module pifr_flag_bank #(
  parameter logic [3:0] OFFSET = 4'h0,
  parameter logic [7:0] IMPL   = 8'hff
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Bus and events
  pifr_bus_if.slave       bus,
  input  wire logic [7:0] i_set,
  // State
  output logic      [7:0] o_flags
);
  logic [7:0] flags;
  logic [7:0] next_flags;

  always_comb begin
    next_flags = flags;
    if (bus.wr && bus.addr == OFFSET) begin
      next_flags = bus.wdata & IMPL;
    end
    // A set in the cycle of a software clear still wins.
    next_flags = next_flags | (i_set & IMPL);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= pifr_pkg::RST_REG;
    end else begin
      flags <= next_flags;
    end
  end

  assign o_flags = flags;
endmodule // pifr_flag_bank

// file: core/pifr_top.sv
// Peripheral interrupt flag registers with enables and request qualification.
module pifr_top (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  // Register port
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Peripheral events
  input  wire logic       i_t1_gate_event,
  input  wire logic       i_adc_done_event,
  input  wire logic       i_t2_period_match_event,
  input  wire logic       i_t1_overflow_event,
  input  wire logic       i_num_osc_overflow_event,
  // Interrupt outputs
  output logic            o_periph_irq_req,
  output logic            o_irq
);
  pifr_bus_if bus ();
  assign bus.addr  = i_addr;
  assign bus.wdata = i_wdata;
  assign bus.wr    = i_wr;

  logic [7:0] periph_irq_flags_a;
  logic [7:0] periph_irq_flags_b;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] enable_a;
  logic [7:0] enable_b;
  logic [7:0] irq_control_reg;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] rdata;
  logic [7:0] next_enable_a;
  logic [7:0] next_enable_b;
  logic [7:0] next_irq_control_reg;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;
  logic [7:0] next_rdata;
  logic       req;
  logic       req_q;
  logic       next_req_q;

  always_comb begin
    set_a = 8'h00;
    set_a[pifr_pkg::BIT_T1_GATE]  = i_t1_gate_event;
    set_a[pifr_pkg::BIT_ADC_DONE] = i_adc_done_event;
    set_a[pifr_pkg::BIT_T2_MATCH] = i_t2_period_match_event;
    set_a[pifr_pkg::BIT_T1_OVF]   = i_t1_overflow_event;
    set_b = 8'h00;
    set_b[pifr_pkg::BIT_NUM_OSC]  = i_num_osc_overflow_event;
  end

  pifr_flag_bank #(
    .OFFSET (pifr_pkg::OFF_FLAGS_A),
    .IMPL   (pifr_pkg::IMPL_MASK_A)
  ) u_flags_a (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bus       (bus),
    .i_set     (set_a),
    .o_flags   (periph_irq_flags_a)
  );

  pifr_flag_bank #(
    .OFFSET (pifr_pkg::OFF_FLAGS_B),
    .IMPL   (pifr_pkg::IMPL_MASK_B)
  ) u_flags_b (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .bus       (bus),
    .i_set     (set_b),
    .o_flags   (periph_irq_flags_b)
  );

  // The request is combinational on registered state, so it moves at the same edge as a flag.
  always_comb begin
    req = (|(periph_irq_flags_a & enable_a)) | (|(periph_irq_flags_b & enable_b));
    req = req & irq_control_reg[pifr_pkg::BIT_PERIPH_EN]
              & irq_control_reg[pifr_pkg::BIT_GLOBAL_EN];
  end

  // Decoding of one strobe against one register index, shared by the enable, control, mask and status registers.
  function automatic logic reg_hit(
    input logic       strobe,
    input logic [3:0] addr,
    input logic [3:0] offset
  );
    return strobe && (addr == offset);
  endfunction

  // Only implemented positions ever hold a one, so unused bits always read zero.
  function automatic logic [7:0] impl_bits(
    input logic [7:0] data,
    input logic [7:0] impl
  );
    return data & impl;
  endfunction

  always_comb begin
    next_enable_a = enable_a;
    if (reg_hit(i_wr, i_addr, pifr_pkg::OFF_ENABLE_A)) begin
      next_enable_a = impl_bits(i_wdata, pifr_pkg::IMPL_MASK_A);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_a <= pifr_pkg::RST_REG;
    end else begin
      enable_a <= next_enable_a;
    end
  end

  always_comb begin
    next_enable_b = enable_b;
    if (reg_hit(i_wr, i_addr, pifr_pkg::OFF_ENABLE_B)) begin
      next_enable_b = impl_bits(i_wdata, pifr_pkg::IMPL_MASK_B);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_b <= pifr_pkg::RST_REG;
    end else begin
      enable_b <= next_enable_b;
    end
  end

  // The two control bits gate the request as a whole, whatever the flags say.
  always_comb begin
    next_irq_control_reg = irq_control_reg;
    if (reg_hit(i_wr, i_addr, pifr_pkg::OFF_IRQ_CTRL)) begin
      next_irq_control_reg = impl_bits(i_wdata, pifr_pkg::IMPL_MASK_CTRL);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_control_reg <= pifr_pkg::RST_REG;
    end else begin
      irq_control_reg <= next_irq_control_reg;
    end
  end

  always_comb begin
    next_irq_mask = irq_mask;
    if (reg_hit(i_wr, i_addr, pifr_pkg::OFF_IRQ_MASK)) begin
      next_irq_mask = impl_bits(i_wdata, pifr_pkg::IMPL_MASK_STAT);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_mask <= pifr_pkg::RST_REG;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  always_comb begin
    next_irq_status = irq_status;
    next_req_q      = req;
    if (reg_hit(i_rd, i_addr, pifr_pkg::OFF_IRQ_STATUS)) begin
      next_irq_status = pifr_pkg::RST_REG;
    end
    // A rising request sets the sticky status and beats a read clear in the same cycle.
    if (req && !req_q) begin
      next_irq_status[0] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= pifr_pkg::RST_REG;
      req_q      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      req_q      <= next_req_q;
    end
  end

  // Read data stands in the cycle after each cycle of i_rd and is zero otherwise, which keeps a shared bus quiet.
  always_comb begin
    next_rdata = pifr_pkg::RST_RDATA;
    if (i_rd) begin
      unique case (i_addr)
        pifr_pkg::OFF_FLAGS_A:    next_rdata = periph_irq_flags_a;
        pifr_pkg::OFF_FLAGS_B:    next_rdata = periph_irq_flags_b;
        pifr_pkg::OFF_ENABLE_A:   next_rdata = enable_a;
        pifr_pkg::OFF_ENABLE_B:   next_rdata = enable_b;
        pifr_pkg::OFF_IRQ_CTRL:   next_rdata = irq_control_reg;
        pifr_pkg::OFF_IRQ_STATUS: next_rdata = irq_status;
        pifr_pkg::OFF_IRQ_MASK:   next_rdata = irq_mask;
        default:                  next_rdata = pifr_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata <= pifr_pkg::RST_RDATA;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata          = rdata;
  assign o_periph_irq_req = req;
  assign o_irq            = |(irq_status & irq_mask);
endmodule // pifr_top

// file: test/pifr_evt_src.sv
// Model of the peripheral event sources.
module pifr_evt_src (
  input  wire logic       i_ref_clk,
  input  wire logic [4:0] i_fire,
  output logic      [4:0] o_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // A source pulses whatever the enables say.
  always @(posedge i_ref_clk) o_evt <= i_fire;
endmodule // pifr_evt_src

// file: test/pifr_monitor.sv
// Checker of the flag block on its top-level ports.
module pifr_monitor (
  input wire logic       i_ref_clk,
  input wire logic       i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_t1_gate_event,
  input wire logic       i_num_osc_overflow_event,
  input wire logic       o_periph_irq_req,
  input wire logic       o_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence rd_at(a); i_rd && i_addr == a; endsequence
  AST_EVT_A: assert property (i_t1_gate_event ##1 rd_at(4'h0) |=> o_rdata[7])
    else $error("Gate flag not set.");
  AST_EVT_B: assert property (i_num_osc_overflow_event ##1 (!(i_wr && i_addr == 4'h1))[*2]
    ##1 rd_at(4'h1) |=> o_rdata[2]) else $error("Oscillator flag not set.");
  AST_WR_A: assert property (i_wr && i_addr == 4'h0 && !i_t1_gate_event ##1 rd_at(4'h0)
    |=> o_rdata[7] == $past(i_wdata[7], 2)) else $error("Gate flag not written.");
  AST_WR_B: assert property (i_wr && i_addr == 4'h1 && !i_num_osc_overflow_event
    ##1 rd_at(4'h1) |=> o_rdata == ($past(i_wdata, 2) & 8'h04)) else $error("Write lost.");
  AST_UNIMP: assert property (rd_at(4'h0) |=> (o_rdata & 8'h3c) == 8'h00)
    else $error("Unused bits not zero.");
  AST_PEN: assert property (rd_at(4'h4) ##1 !o_rdata[6] |-> !o_periph_irq_req)
    else $error("Request without periph enable.");
  AST_GEN: assert property (rd_at(4'h4) ##1 !o_rdata[7] |-> !o_periph_irq_req)
    else $error("Request without global enable.");
  AST_RST: assert property (disable iff (1'b0) !i_rst_n |=> o_rdata == 8'h00 && !o_irq)
    else $error("Outputs not clear in reset.");
  cover property (o_irq);
  cover property (o_periph_irq_req);
  cover property (rd_at(4'h5) ##1 o_rdata[0]);
endmodule // pifr_monitor

// file: test/test_peripheral_irq_flag_regs.sv
// Self-checking bench of the peripheral flag block.
module test_peripheral_irq_flag_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [4:0] fire = 5'h00;
  logic [4:0] evt;
  logic [7:0] rdata;
  logic       req;
  logic       irq;
  logic [7:0] d;
  logic [4:0] f;
  int         err_count = 0;
  int         checks_done = 0;
  initial forever #2 clk = ~clk;
  pifr_evt_src pifr_evt_src_i (.i_ref_clk(clk), .i_fire(fire), .o_evt(evt));
  pifr_top pifr_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_t1_gate_event(evt[4]),
    .i_adc_done_event(evt[3]), .i_t2_period_match_event(evt[2]),
    .i_t1_overflow_event(evt[1]), .i_num_osc_overflow_event(evt[0]),
    .o_periph_irq_req(req), .o_irq(irq));
  function automatic logic [7:0] exp_flag(input logic b, input logic [4:0] x);
    return b ? {5'h00, x[0], 2'h0} : {x[4:3], 4'h0, x[2:1]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk) wr <= 1'b0;
  endtask
  // The strobe drops at once, so a read always follows a write without a gap.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
    @(posedge clk);
  endtask
  task automatic pulse(input logic [4:0] x);
    fire <= x;
    @(posedge clk) fire <= 5'h00;
    @(posedge clk);
  endtask
  task automatic end_sim;
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    end_sim;
  end
  initial begin
    void'($urandom(51));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++) rd_reg(a[3:0], 8'h00);
    repeat (20) begin
      d = 8'($urandom);
      f = 5'($urandom);
      wr_reg({3'h0, f[0]}, d);
      rd_reg({3'h0, f[0]}, d & exp_flag(f[0], 5'h1f));
    end
    wr_reg(4'hf, 8'hff);
    rd_reg(4'hf, 8'h00);
    repeat (10) begin
      f = 5'($urandom);
      wr_reg(4'h0, 8'h00);
      rd_reg(4'h0, 8'h00);
      wr_reg(4'h1, 8'h00);
      rd_reg(4'h1, 8'h00);
      pulse(f);
      rd_reg(4'h0, exp_flag(1'b0, f));
      rd_reg(4'h1, exp_flag(1'b1, f));
    end
    // The gate event lands in the very cycle of a software clear.
    fire <= 5'h10;
    @(posedge clk) fire <= 5'h00;
    wr_reg(4'h0, 8'h00);
    rd_reg(4'h0, 8'h80);
    wr_reg(4'h6, 8'h01);
    rd_reg(4'h6, 8'h01);
    wr_reg(4'h2, 8'h01);
    rd_reg(4'h2, 8'h01);
    pulse(5'h02);
    for (int c = 0; c < 3; c++) begin
      d = (c == 0) ? 8'h40 : (c == 1) ? 8'h80 : 8'hc0;
      wr_reg(4'h4, d);
      rd_reg(4'h4, d);
      chk({7'h00, req}, {7'h00, c == 2});
    end
    chk({7'h00, irq}, 8'h01);
    rd_reg(4'h5, 8'h01);
    rd_reg(4'h5, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr_reg(4'h2, 8'h00);
    rd_reg(4'h2, 8'h00);
    wr_reg(4'h1, 8'h00);
    rd_reg(4'h1, 8'h00);
    wr_reg(4'h3, 8'hff);
    rd_reg(4'h3, 8'h04);
    chk({7'h00, req}, 8'h00);
    pulse(5'h01);
    rd_reg(4'h1, 8'h04);
    chk({7'h00, req}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(4'h0, 8'h00);
    rd_reg(4'h4, 8'h00);
    end_sim;
  end
endmodule // test_peripheral_irq_flag_regs
bind pifr_top pifr_monitor pifr_monitor_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_t1_gate_event(i_t1_gate_event), .i_num_osc_overflow_event(i_num_osc_overflow_event),
  .o_periph_irq_req(o_periph_irq_req), .o_irq(o_irq));
